//--- logic/hvm_status_regs.sv
// Level monitor and change-of-state registers behind indirect ports
// Functional notes
// - Level monitor: 8-bit, read-only, resets zero.
// - Reached only through command and data ports.
// - Bit 7 follows wake pin in I/O mode.
// - Bit 6 shows thermal shutdown occurred.
// - Bit 5 follows second pin in I/O mode.
// - Bit 4 shows converter input buffer enabled.
// - Bit 3 low when supply fell, if enabled.
// - Low-voltage flag cleared only by rewriting its enable bit.
// - Bit 2 bus short; cleared by re-enable write.
// - Bit 1 second short; cleared by re-enable.
// - Bit 0 shows wake driver short circuit.
// - Change register records monitor bit changes.
// - Interrupt rising while idle copies change register to data port.
// - Busy bit held during transfer, about 10us.
// - Re-enable bit clears pending flags, self-clears.
// - Reading change register clears its bus and second short bits.
`include "hvm_cfg.svh"

module hvm_status_regs #(
    parameter int XFER_CYCLES = `HVM_XFER_CYCLES
) (
    // Clock and reset
    input  wire logic                core_clk,
    input  wire logic                srst,
    // Command port
    input  wire hvm_pkg::hvm_cmd_t   cmd,
    output logic [7:0]               hv_command_port,
    output logic [7:0]               hv_data_port,
    // Interrupt
    input  wire logic                hv_irq_enable,
    output logic                     hv_interrupt_line,
    // Pins and analog status (asynchronous)
    input  wire hvm_pkg::hvm_events_t hv_events,
    // Driver re-enable request
    output logic                     drivers_reenable
);
    import hvm_pkg::*;

    localparam int CW = $clog2(XFER_CYCLES + 1);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        hvm_state_t   fsm;
        logic [CW-1:0] count;
        logic [7:0]   config_zero;
        logic [7:0]   config_one;
        logic [7:0]   level;
        logic [7:0]   change;
        logic [7:0]   data;
        logic [7:0]   port_data;
        logic         busy;
        logic         ok;
        logic         lvf_latch;
        logic         bus_short;
        logic         second_short;
        logic         reenable;
        logic         irq_prev;
    } hvm_regs_t;

    hvm_regs_t   r;
    hvm_regs_t   next_r;
    hvm_events_t ev;
    logic [7:0]  live;
    logic [7:0]  toggled;
    logic [7:0]  read_value;
    logic        write_take;
    logic        read_take;

    // Every pin-side input is retimed before use
    hvm_sync #(
        .WIDTH ($bits(hvm_events_t))
    ) u_sync (
        .core_clk (core_clk),
        .srst     (srst),
        .async_in (hv_events),
        .sync_out (ev)
    );

    // ****************************************************************
    // Command decode
    // ****************************************************************
    // A command is refused silently while a transfer is running; with both
    // strobes raised in the same cycle, the op field alone picks read or write
    assign write_take = (r.fsm == HVM_IDLE) && cmd.wr
                        && (cmd.op == `HVM_CMD_WRITE_OP);
    assign read_take  = (r.fsm == HVM_IDLE) && !write_take && cmd.rd
                        && (cmd.op == `HVM_CMD_READ_OP);

    // ****************************************************************
    // Indirect read selection
    // ****************************************************************
    always_comb
    begin
        case (cmd.index)
            `HVM_IDX_LEVEL_MONITOR:
                read_value = live;
            `HVM_IDX_CHANGE_STATUS:
                read_value = r.change;
            `HVM_IDX_CONFIG_ZERO:
                read_value = r.config_zero;
            `HVM_IDX_CONFIG_ONE:
                read_value = r.config_one;
            // Unknown indices read as zero rather than aliasing
            default:
                read_value = 8'h00;
        endcase
    end

    // ****************************************************************
    // Per-bit change detection
    // ****************************************************************
    // Both directions count; several toggles between reads show as one
    for (genvar b = 0; b < 8; b++)
    begin : g_toggle
        assign toggled[b] = live[b] ^ r.level[b];
    end

    // ****************************************************************
    // Live monitor value
    // ****************************************************************
    always_comb
    begin
        live = r.level;
        // Readbacks only follow the pins in I/O mode
        if (r.config_one[`HVM_CFG1_PIN_IO])
        begin
            live[`HVM_MON_WAKE_READ]   = ev.wake_pin;
            live[`HVM_MON_SECOND_READ] = ev.second_pin;
        end
        live[`HVM_MON_OVERTEMP]     = ev.overtemp;
        live[`HVM_MON_BUFFER_ON]    = ev.buffer_on;
        live[`HVM_MON_LOW_VOLT]     = r.config_zero[`HVM_CFG0_LVF_EN]
                                      & ~r.lvf_latch;
        live[`HVM_MON_BUS_SHORT]    = r.bus_short;
        live[`HVM_MON_SECOND_SHORT] = r.second_short;
        live[`HVM_MON_WAKE_SHORT]   = ev.wake_short;
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        logic irq_now;
        logic change_read;
        logic reenable_wr;
        irq_now     = 1'b0;
        change_read = 1'b0;
        reenable_wr = 1'b0;
        next_r      = r;
        next_r.reenable = 1'b0;

        // ************************************************************
        // Indirect commands
        // ************************************************************
        if (write_take)
        begin
            case (cmd.index)
                `HVM_IDX_CONFIG_ZERO:
                begin
                    next_r.config_zero = cmd.wdata;
                    // Re-enabling the flag re-arms the latch
                    if (cmd.wdata[`HVM_CFG0_LVF_EN])
                    begin
                        next_r.lvf_latch = 1'b0;
                    end
                end
                `HVM_IDX_CONFIG_ONE:
                begin
                    next_r.config_one = cmd.wdata;
                    next_r.config_one[`HVM_CFG1_REENABLE] = 1'b0;
                    reenable_wr = cmd.wdata[`HVM_CFG1_REENABLE];
                end
                default:
                begin
                end
            endcase
        end
        else if (read_take)
        begin
            next_r.fsm   = HVM_BUSY;
            next_r.count = CW'(XFER_CYCLES);
            next_r.ok    = 1'b0;
            next_r.data  = read_value;
            change_read  = (cmd.index == `HVM_IDX_CHANGE_STATUS);
        end

        // ************************************************************
        // Automatic transfer
        // ************************************************************
        // Only started from idle: an interrupt that rises during a
        // software read is not copied, the handler must read it itself
        irq_now = hv_irq_enable & (|r.change);
        if (irq_now && !r.irq_prev && r.fsm == HVM_IDLE)
        begin
            next_r.fsm   = HVM_BUSY;
            next_r.count = CW'(XFER_CYCLES);
            next_r.ok    = 1'b0;
            next_r.data  = r.change;
        end
        next_r.irq_prev = irq_now;

        // ************************************************************
        // Transfer timer
        // ************************************************************
        case (r.fsm)
            HVM_BUSY:
            begin
                if (r.count <= CW'(1))
                begin
                    next_r.fsm = HVM_IDLE;
                    next_r.ok  = 1'b1;
                end
                else
                begin
                    next_r.count = r.count - CW'(1);
                end
            end
            default:
            begin
            end
        endcase
        next_r.busy = (next_r.fsm == HVM_BUSY);
        // Data port reads zero until the transfer has completed
        next_r.port_data = next_r.ok ? next_r.data : 8'h00;

        // ************************************************************
        // Sticky flags
        // ************************************************************
        // A new event beats a clear in the same cycle, so a short that
        // persists through the re-enable write is never lost
        if (reenable_wr)
        begin
            next_r.bus_short    = 1'b0;
            next_r.second_short = 1'b0;
            next_r.reenable     = 1'b1;
        end
        if (ev.bus_short)
        begin
            next_r.bus_short = 1'b1;
        end
        if (ev.second_short)
        begin
            next_r.second_short = 1'b1;
        end
        if (ev.supply_low)
        begin
            next_r.lvf_latch = 1'b1;
        end

        // ************************************************************
        // Change-of-state capture
        // ************************************************************
        if (reenable_wr)
        begin
            next_r.change = 8'h00;
        end
        if (change_read)
        begin
            next_r.change[`HVM_MON_BUS_SHORT]    = 1'b0;
            next_r.change[`HVM_MON_SECOND_SHORT] = 1'b0;
        end
        next_r.change = next_r.change | toggled;
        next_r.level  = live;
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            r             <= '0;
            r.fsm         <= HVM_IDLE;
            r.level       <= `HVM_LEVEL_RESET;
            r.change      <= `HVM_CHANGE_RESET;
            r.config_zero <= `HVM_CONFIG_RESET;
            r.config_one  <= `HVM_CONFIG_RESET;
        end
        else
            r <= next_r;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    always_comb
    begin
        hv_command_port = 8'h00;
        hv_command_port[`HVM_CMD_BUSY_BIT] = r.busy;
        hv_command_port[`HVM_CMD_OK_BIT]   = r.ok;
    end
    // Registered copy, so the port never shows a half-updated value
    assign hv_data_port      = r.port_data;
    assign hv_interrupt_line = r.irq_prev;
    assign drivers_reenable  = r.reenable;

endmodule // hvm_status_regs

//--- logic/hvm_sync.sv
// Two-stage synchroniser for a group of asynchronous inputs
module hvm_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             srst,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_one;

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            stage_one <= '0;
            sync_out  <= '0;
        end
        else
        begin
            stage_one <= async_in;
            sync_out  <= stage_one;
        end
    end

endmodule // hvm_sync

//--- shared/hvm_cfg.svh
// Offsets, bit positions, reset values and timing counts of the monitor
`ifndef HVM_CFG_SVH
`define HVM_CFG_SVH

// ****************************************************************
// Indirect register indices
// ****************************************************************
`define HVM_IDX_LEVEL_MONITOR   8'h00
`define HVM_IDX_CHANGE_STATUS   8'h01
`define HVM_IDX_CONFIG_ZERO     8'h02
`define HVM_IDX_CONFIG_ONE      8'h03

// ****************************************************************
// Command port layout
// ****************************************************************
`define HVM_CMD_BUSY_BIT        0
`define HVM_CMD_OK_BIT          1
`define HVM_CMD_READ_OP         2'h1
`define HVM_CMD_WRITE_OP        2'h2

// ****************************************************************
// Field positions
// ****************************************************************
`define HVM_MON_WAKE_READ       7
`define HVM_MON_OVERTEMP        6
`define HVM_MON_SECOND_READ     5
`define HVM_MON_BUFFER_ON       4
`define HVM_MON_LOW_VOLT        3
`define HVM_MON_BUS_SHORT       2
`define HVM_MON_SECOND_SHORT    1
`define HVM_MON_WAKE_SHORT      0
`define HVM_CFG0_LVF_EN         2
`define HVM_CFG1_REENABLE       3
`define HVM_CFG1_PIN_IO         4

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define HVM_LEVEL_RESET         8'h00
`define HVM_CHANGE_RESET        8'h00
`define HVM_CONFIG_RESET        8'h00
`define HVM_CLK_MHZ             250
`define HVM_XFER_US             10
`define HVM_XFER_CYCLES         (`HVM_XFER_US * `HVM_CLK_MHZ)

`endif

//--- shared/hvm_pkg.sv
// Types shared by the monitor status logic
package hvm_pkg;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [1:0] op;
        logic [7:0] index;
        logic [7:0] wdata;
    } hvm_cmd_t;

    typedef struct packed {
        logic wake_pin;
        logic second_pin;
        logic overtemp;
        logic buffer_on;
        logic supply_low;
        logic bus_short;
        logic second_short;
        logic wake_short;
    } hvm_events_t;

    typedef enum logic [1:0] {
        HVM_IDLE,
        HVM_BUSY
    } hvm_state_t;

endpackage

//--- verif/hvm_core_model.sv
// Core-side model making indirect accesses through the command port
module hvm_core_model (
    // Clock
    input  wire logic       core_clk,
    // Command side
    output hvm_pkg::hvm_cmd_t cmd,
    input  wire logic [7:0] hv_command_port,
    input  wire logic [7:0] hv_data_port
);
    timeunit 1ns;
    timeprecision 100ps;
    import hvm_pkg::*;
    initial cmd = '0;
    // One-cycle strobe; no idle wait, so a refused case can be made
    task automatic send(input logic [1:0] op, input logic [7:0] idx, wd);
        @(posedge core_clk);
        #1 cmd = '{op == 2'h2, op == 2'h1, op, idx, wd};
        @(posedge core_clk);
        #1 cmd = '0;
    endtask
    task automatic read(input logic [7:0] idx, output logic [7:0] d);
        repeat (64) if (hv_command_port[0] !== 1'b0) @(posedge core_clk) #1;
        send(2'h1, idx, 8'h00);
        repeat (64) if (hv_command_port[0] !== 1'b0) @(posedge core_clk) #1;
        d = hv_command_port[1] === 1'b1 ? hv_data_port : 8'hxx;
    endtask
endmodule // hvm_core_model

//--- verif/hvm_status_regs_properties.sv
// Port checker for the monitor status registers
module hvm_status_regs_properties #(
    parameter int XFER_CYCLES = 2500
) (
    // Clock and reset
    input wire logic                 core_clk,
    input wire logic                 srst,
    // Command side
    input wire hvm_pkg::hvm_cmd_t    cmd,
    input wire logic [7:0]           hv_command_port,
    input wire logic [7:0]           hv_data_port,
    // Interrupt and pins
    input wire logic                 hv_irq_enable,
    input wire logic                 hv_interrupt_line,
    input wire hvm_pkg::hvm_events_t hv_events,
    input wire logic                 drivers_reenable
);
    timeunit 1ns;
    timeprecision 100ps;
    import hvm_pkg::*;
    logic busy;
    logic rd_take;
    logic reen_take;
    int   run;
    assign busy = hv_command_port[0];
    assign rd_take = !busy && cmd.rd && !cmd.wr && cmd.op == 2'h1;
    assign reen_take = !busy && cmd.wr && cmd.op == 2'h2
                       && cmd.index == 8'h03 && cmd.wdata[3];
    // Busy run length, so the transfer time is checked exactly
    always_ff @(posedge core_clk)
    begin
        if (srst || !busy)
            run <= 0;
        else
            run <= run + 1;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    property p_read_busy; rd_take |=> busy && !hv_command_port[1]; endproperty
    a_read_busy: assert property (p_read_busy) else $error("no busy");
    property p_busy_len; busy |-> run <= XFER_CYCLES - 1; endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy long");
    property p_busy_end;
        $fell(busy) |-> run == XFER_CYCLES && hv_command_port[1];
    endproperty
    a_busy_end: assert property (p_busy_end) else $error("bad end");
    property p_zero_busy; busy |-> hv_data_port == 8'h00; endproperty
    a_zero_busy: assert property (p_zero_busy) else $error("data");
    property p_data_hold; !busy && $past(!busy) |-> $stable(hv_data_port);
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("moved");
    property p_irq_off; !hv_irq_enable |=> !hv_interrupt_line; endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq on");
    property p_irq_xfer; $rose(hv_interrupt_line) && $past(!busy) |-> busy;
    endproperty
    a_irq_xfer: assert property (p_irq_xfer) else $error("no copy");
    property p_reen; reen_take |=> drivers_reenable ##1 !drivers_reenable;
    endproperty
    a_reen: assert property (p_reen) else $error("reenable");
endmodule // hvm_status_regs_properties

bind hvm_status_regs hvm_status_regs_properties #(
    .XFER_CYCLES(XFER_CYCLES)
) i_props (.core_clk, .srst, .cmd, .hv_command_port, .hv_data_port,
    .hv_irq_enable, .hv_interrupt_line, .hv_events, .drivers_reenable);

//--- verif/tb.sv
// Self-checking bench for the monitor status registers
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import hvm_pkg::*;
    typedef struct { logic [7:0] ev, mon; } hvm_row_t;
    localparam int N = 8;
    logic        core_clk = 0;
    logic        srst = 1;
    logic        irq_en = 0;
    hvm_events_t ev = '0;
    hvm_cmd_t    cmd;
    logic [7:0]  cp, dp, d;
    logic        irq, reen;
    int          err_count = 0, checked = 0, i;
    hvm_row_t    rows [10] = '{'{8'h00, 8'h08}, '{8'h80, 8'h88},
        '{8'h40, 8'h28}, '{8'h20, 8'h48}, '{8'h10, 8'h18}, '{8'h01, 8'h09},
        '{8'h06, 8'h0e}, '{8'h00, 8'h0e}, '{8'h08, 8'h06}, '{8'h00, 8'h06}};
    always #2 core_clk = ~core_clk;
    hvm_status_regs #(.XFER_CYCLES(N)) i_hvm_status_regs (.core_clk, .srst,
        .cmd, .hv_command_port(cp), .hv_data_port(dp), .hv_irq_enable(irq_en),
        .hv_interrupt_line(irq), .hv_events(ev), .drivers_reenable(reen));
    hvm_core_model i_hvm_core_model (.core_clk, .cmd, .hv_command_port(cp),
        .hv_data_port(dp));
    task automatic step(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    task automatic rd(input logic [7:0] idx);
        i_hvm_core_model.read(idx, d);
    endtask
    task automatic wr(input logic [7:0] idx, wd);
        i_hvm_core_model.send(2'h2, idx, wd);
    endtask
    task automatic end_sim;
        $display("checked=%0d err_count=%0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Watchdog well beyond the few hundred cycles the tests need
    initial
    begin
        #50000;
        err_count++;
        end_sim();
    end
    initial
    begin
        step(16);
        srst = 0;
        `CHK(cp, 8'h00)
        rd(8'h00);
        `CHK(d, 8'h00)
        rd(8'h01);
        `CHK(d, 8'h00)
        rd(8'h05);
        `CHK(d, 8'h00)
        $display("test reset done");
        wr(8'h02, 8'h04);
        wr(8'h03, 8'h10);
        for (i = 0; i < 10; i++)
        begin
            ev = rows[i].ev;
            step(4);
            rd(8'h00);
            `CHK(d, rows[i].mon)
        end
        $display("test rows done");
        wr(8'h03, 8'h18);
        `CHK(reen, 1'b1)
        step(1);
        `CHK(reen, 1'b0)
        rd(8'h03);
        `CHK(d, 8'h10)
        rd(8'h00);
        `CHK(d, 8'h00)
        wr(8'h02, 8'h04);
        rd(8'h00);
        `CHK(d, 8'h08)
        rd(8'h02);
        `CHK(d, 8'h04)
        wr(8'h03, 8'h00);
        ev = 8'hc0;
        step(4);
        rd(8'h00);
        `CHK(d, 8'h08)
        ev = 8'h00;
        i_hvm_core_model.send(2'h1, 8'h00, 8'h00);
        step(2);
        wr(8'h03, 8'h08);
        `CHK(reen, 1'b0)
        rd(8'h00);
        `CHK(d, 8'h08)
        $display("test clear done");
        srst = 1;
        step(3);
        srst = 0;
        `CHK(cp, 8'h00)
        ev = 8'h20;
        step(4);
        rd(8'h01);
        `CHK(d, 8'h40)
        irq_en = 1;
        step(2);
        `CHK(irq, 1'b1)
        for (i = 0; i < 20 && cp[0] !== 1'b0; i++)
            step(1);
        `CHK(cp, 8'h02)
        `CHK(dp, 8'h40)
        ev = 8'h24;
        step(4);
        rd(8'h01);
        `CHK(d, 8'h44)
        rd(8'h01);
        `CHK(d, 8'h40)
        irq_en = 0;
        step(2);
        `CHK(irq, 1'b0)
        $display("test irq done");
        end_sim();
    end
endmodule // tb
